// ==== rtl/das_cvt.sv ====
// Purpose: Drives one sample-and-hold plus converter, captures its result
// Assumes: adc_done is a one-cycle pulse with adc_data valid in that cycle
// Notes:   Sample strobe and convert start are the same pulse
`timescale 1ns/1ps
module das_cvt #(parameter int RES_W = 12)
(
	input  wire logic             clk_sys,
	input  wire logic             rst_int_n,
	das_cvt_if.cvt                cv,
	output logic                  adc_start,
	output logic [2:0]            adc_ch,
	input  wire logic             adc_done,
	input  wire logic [RES_W-1:0] adc_data
);

	logic             busy_q;
	logic             start_q;
	logic [2:0]       ch_q;
	logic             done_q;
	logic [RES_W-1:0] res_q;

	assign adc_start = start_q;
	assign adc_ch    = ch_q;
	assign cv.done   = done_q;
	assign cv.res    = res_q;

	// ****************************************************************
	// Start and capture
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			busy_q  <= 1'b0;
			start_q <= 1'b0;
			ch_q    <= 3'h0;
			done_q  <= 1'b0;
			res_q   <= '0;
		end
		else
		begin
			start_q <= 1'b0;
			done_q  <= 1'b0;
			if (cv.req && !busy_q)
			begin
				ch_q    <= cv.ch;
				start_q <= 1'b1;
				busy_q  <= 1'b1;
			end
			else if (busy_q && adc_done)
			begin
				res_q  <= adc_data;
				done_q <= 1'b1;
				busy_q <= 1'b0;
			end
		end
	end

endmodule : das_cvt

// ==== rtl/das_cvt_if.sv ====
// Purpose: Request/answer path between the sequencer and one converter port
// Assumes: One clock
// Notes:   res stays stable after done until the next req
`timescale 1ns/1ps
interface das_cvt_if #(parameter int RES_W = 12);
	logic             req;
	logic [2:0]       ch;
	logic             done;
	logic [RES_W-1:0] res;

	modport seq (output req, output ch, input done, input res);
	modport cvt (input req, input ch, output done, output res);
endinterface : das_cvt_if

// ==== rtl/das_defines.svh ====
// Purpose: Register map, field positions, reset values of the scan sequencer
// Assumes: 32-bit Avalon-MM slave, byte addresses, one word per register
// Notes:   Definitions only
`ifndef DAS_DEFINES_SVH
`define DAS_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define DAS_OFF_CTRL     7'h00
`define DAS_OFF_STATUS   7'h04
`define DAS_OFF_MASK     7'h08
`define DAS_OFF_CHLIST   7'h0c
`define DAS_OFF_ZCCTRL   7'h10
`define DAS_RES_PAGE     2'h1
`define DAS_LIM_PAGE     2'h2

// ****************************************************************
// Fields
// ****************************************************************
`define DAS_CTRL_MODE_LSB 0
`define DAS_CTRL_SIMUL    2
`define DAS_CTRL_START    3
`define DAS_CTRL_STOP     4
`define DAS_CTRL_LAST_LSB 8
`define DAS_STAT_END      0
`define DAS_STAT_OOR      1
`define DAS_STAT_ZC       2
`define DAS_STAT_BUSY     8
`define DAS_LIM_HI_LSB    16

// ****************************************************************
// Reset values
// ****************************************************************
`define DAS_CTRL_RST     11'h700
`define DAS_CHLIST_RST   32'h76543210
`define DAS_ZC_RST       16'h0000
`define DAS_LIM_LO_RST   12'h000
`define DAS_LIM_HI_RST   12'hfff
`define DAS_ZC_MID       12'h800

`endif

// ==== rtl/das_pkg.sv ====
// Purpose: Types shared by the scan sequencer
// Assumes: Nothing
// Notes:   Constants live in das_defines.svh
package das_pkg;

	typedef enum logic [1:0] {DAS_MODE_ONCE, DAS_MODE_TRIG, DAS_MODE_LOOP, DAS_MODE_RSVD} das_mode_t;

	typedef enum logic [1:0] {DAS_ZC_OFF, DAS_ZC_RISE, DAS_ZC_FALL, DAS_ZC_ANY} das_zc_t;

	typedef enum logic [1:0] {DAS_S_IDLE, DAS_S_ISSUE, DAS_S_WAIT, DAS_S_END} das_state_t;

endpackage : das_pkg

// ==== rtl/das_top.sv ====
// Purpose: Scan sequencer for an eight-input mux feeding two S/H + 12-bit converters
// Assumes: All inputs synchronous to clk_sys (125 MHz); converters answer with done
// Notes:   Registers over Avalon-MM with waitrequest; read of STATUS clears it
//
// Overview of operation
// - Any of eight inputs is routed to one of two S/H stages, each with its own 12-bit converter, results readable.
// - Three scan modes: one scan then halt, one scan per trigger, and repeated scans until stopped.
// - A control bit selects sequential or simultaneous conversion.
// - Sequential scans take up to eight list slots in list order, storing each result at its slot.
// - In sequential scans the converter is chosen from the channel named (0-3 first, 4-7 second).
// - In simultaneous scans both S/H stages capture together, each on its own channel.
// - If enabled, an out-of-range result raises an interrupt at the end of the scan.
// - If enabled, a selectable zero-crossing condition on the results raises an interrupt.
`timescale 1ns/1ps
`include "das_defines.svh"
module das_top #(
	parameter int NCH   = 8,
	parameter int RES_W = 12
)
(
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic [6:0]       avs_address,
	input  wire logic             avs_read,
	input  wire logic             avs_write,
	input  wire logic [31:0]      avs_writedata,
	output logic [31:0]           avs_readdata,
	output logic                  avs_waitrequest,
	input  wire logic             trig,
	output logic                  irq,
	output logic                  adc_a_start,
	output logic [2:0]            adc_a_ch,
	input  wire logic             adc_a_done,
	input  wire logic [RES_W-1:0] adc_a_data,
	output logic                  adc_b_start,
	output logic [2:0]            adc_b_ch,
	input  wire logic             adc_b_done,
	input  wire logic [RES_W-1:0] adc_b_data
);

	// ****************************************************************
	// Functions
	// ****************************************************************
	function automatic logic [2:0] list_ch(input logic [31:0] list, input logic [2:0] idx);
		list_ch = list[{idx, 2'b00} +: 3];
	endfunction : list_ch

	function automatic logic out_of_range(input logic [RES_W-1:0] v, input logic [RES_W-1:0] lo,
		input logic [RES_W-1:0] hi);
		out_of_range = (v < lo) || (v > hi);
	endfunction : out_of_range

	function automatic logic zc_hit(input logic [1:0] mode, input logic seen, input logic was_pos,
		input logic now_pos);
		logic rise;
		logic fall;
		rise = seen && !was_pos && now_pos;
		fall = seen && was_pos && !now_pos;
		unique case (das_pkg::das_zc_t'(mode))
			das_pkg::DAS_ZC_OFF:  zc_hit = 1'b0;
			das_pkg::DAS_ZC_RISE: zc_hit = rise;
			das_pkg::DAS_ZC_FALL: zc_hit = fall;
			das_pkg::DAS_ZC_ANY:  zc_hit = rise || fall;
		endcase
	endfunction : zc_hit

	// ****************************************************************
	// Reset release
	// ****************************************************************
	logic [1:0] rst_sync_q;
	logic       rst_int_n;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_int_n = rst_sync_q[1];

	// ****************************************************************
	// Declarations
	// ****************************************************************
	das_pkg::das_state_t state_q;
	das_pkg::das_mode_t  mode_q;
	logic                simul_q;
	logic [2:0]          last_q;
	logic [31:0]         chlist_q;
	logic [15:0]         zcsel_q;
	logic [2:0]          mask_q;
	logic [2:0]          status_q;
	logic [RES_W-1:0]    lim_lo_q [NCH];
	logic [RES_W-1:0]    lim_hi_q [NCH];
	logic [RES_W-1:0]    result_q [NCH];
	logic [NCH-1:0]      pos_q;
	logic [NCH-1:0]      seen_q;
	logic                start_pend_q;
	logic                stop_pend_q;
	logic                trig_q;
	logic                trig_prev_q;
	logic [2:0]          slot_q;
	logic [1:0]          need_q;
	logic [1:0]          got_q;
	logic                oor_q;
	logic                zc_q;
	logic [1:0]          req_q;
	logic [2:0]          ch_a_q;
	logic [2:0]          ch_b_q;
	logic                wait_q;
	logic [31:0]         rdata_q;
	logic                irq_q;
	logic [31:0]         rdata_d;
	logic                acc;
	logic                wr_acc;
	logic                rd_status;
	logic                trig_evt;
	logic                go;
	logic [1:0]          got_d;
	logic                all_done;
	logic [3:0]          next_slot;
	logic                lane_vld [2];
	logic [2:0]          lane_idx [2];
	logic [RES_W-1:0]    lane_res [2];

	das_cvt_if #(.RES_W(RES_W)) cvt_a ();
	das_cvt_if #(.RES_W(RES_W)) cvt_b ();

	assign cvt_a.req = req_q[0];
	assign cvt_a.ch  = ch_a_q;
	assign cvt_b.req = req_q[1];
	assign cvt_b.ch  = ch_b_q;

	das_cvt #(.RES_W(RES_W)) u_cvt_a (
		.clk_sys   (clk_sys),
		.rst_int_n (rst_int_n),
		.cv        (cvt_a.cvt),
		.adc_start (adc_a_start),
		.adc_ch    (adc_a_ch),
		.adc_done  (adc_a_done),
		.adc_data  (adc_a_data)
	);

	das_cvt #(.RES_W(RES_W)) u_cvt_b (
		.clk_sys   (clk_sys),
		.rst_int_n (rst_int_n),
		.cv        (cvt_b.cvt),
		.adc_start (adc_b_start),
		.adc_ch    (adc_b_ch),
		.adc_done  (adc_b_done),
		.adc_data  (adc_b_data)
	);

	// ****************************************************************
	// Avalon slave: one wait cycle, access takes effect when waitrequest is low
	// ****************************************************************
	assign acc       = (avs_read || avs_write) && !wait_q;
	assign wr_acc    = acc && avs_write;
	assign rd_status = acc && avs_read && (avs_address == `DAS_OFF_STATUS);

	assign avs_waitrequest = wait_q;
	assign avs_readdata    = rdata_q;
	assign irq             = irq_q;

	always_comb
	begin
		rdata_d = 32'h0;
		if (avs_address[6:5] == `DAS_RES_PAGE)
			rdata_d[RES_W-1:0] = result_q[avs_address[4:2]];
		else if (avs_address[6:5] == `DAS_LIM_PAGE)
		begin
			rdata_d[RES_W-1:0] = lim_lo_q[avs_address[4:2]];
			rdata_d[`DAS_LIM_HI_LSB +: RES_W] = lim_hi_q[avs_address[4:2]];
		end
		else
		begin
			unique case (avs_address)
				`DAS_OFF_CTRL:
				begin
					rdata_d[`DAS_CTRL_MODE_LSB +: 2] = mode_q;
					rdata_d[`DAS_CTRL_SIMUL]         = simul_q;
					rdata_d[`DAS_CTRL_LAST_LSB +: 3] = last_q;
				end
				`DAS_OFF_STATUS:
				begin
					rdata_d[2:0]            = status_q;
					rdata_d[`DAS_STAT_BUSY] = (state_q != das_pkg::DAS_S_IDLE);
				end
				`DAS_OFF_MASK:   rdata_d[2:0]  = mask_q;
				`DAS_OFF_CHLIST: rdata_d       = chlist_q;
				`DAS_OFF_ZCCTRL: rdata_d[15:0] = zcsel_q;
				default:         rdata_d       = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0;
		end
		else
		begin
			// Data is loaded on the edge that drops waitrequest, so it stands while it is low
			wait_q <= !((avs_read || avs_write) && wait_q);
			if ((avs_read || avs_write) && wait_q)
				rdata_q <= rdata_d;
		end
	end

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			mode_q   <= das_pkg::das_mode_t'(2'(`DAS_CTRL_RST >> `DAS_CTRL_MODE_LSB));
			simul_q  <= 1'(`DAS_CTRL_RST >> `DAS_CTRL_SIMUL);
			last_q   <= 3'(`DAS_CTRL_RST >> `DAS_CTRL_LAST_LSB);
			chlist_q <= `DAS_CHLIST_RST;
			zcsel_q  <= `DAS_ZC_RST;
			mask_q   <= 3'h0;
			for (int i = 0; i < NCH; i++)
			begin
				lim_lo_q[i] <= `DAS_LIM_LO_RST;
				lim_hi_q[i] <= `DAS_LIM_HI_RST;
			end
		end
		else if (wr_acc)
		begin
			if (avs_address[6:5] == `DAS_LIM_PAGE)
			begin
				lim_lo_q[avs_address[4:2]] <= avs_writedata[RES_W-1:0];
				lim_hi_q[avs_address[4:2]] <= avs_writedata[`DAS_LIM_HI_LSB +: RES_W];
			end
			else if (avs_address == `DAS_OFF_CTRL)
			begin
				mode_q  <= das_pkg::das_mode_t'(avs_writedata[`DAS_CTRL_MODE_LSB +: 2]);
				simul_q <= avs_writedata[`DAS_CTRL_SIMUL];
				last_q  <= avs_writedata[`DAS_CTRL_LAST_LSB +: 3];
			end
			else if (avs_address == `DAS_OFF_CHLIST)
				chlist_q <= avs_writedata;
			else if (avs_address == `DAS_OFF_ZCCTRL)
				zcsel_q <= avs_writedata[15:0];
			else if (avs_address == `DAS_OFF_MASK)
				mask_q <= avs_writedata[2:0];
		end
	end

	// ****************************************************************
	// Start, stop and trigger
	// ****************************************************************
	assign trig_evt = trig_q && !trig_prev_q;
	assign go = (state_q == das_pkg::DAS_S_IDLE) &&
		((mode_q == das_pkg::DAS_MODE_TRIG) ? trig_evt : start_pend_q);

	always_ff @(posedge clk_sys or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			trig_q       <= 1'b0;
			trig_prev_q  <= 1'b0;
			start_pend_q <= 1'b0;
			stop_pend_q  <= 1'b0;
		end
		else
		begin
			trig_q      <= trig;
			trig_prev_q <= trig_q;
			// Start is a one-shot; in triggered mode it is dropped since only the trigger runs a scan
			if (wr_acc && avs_address == `DAS_OFF_CTRL && avs_writedata[`DAS_CTRL_START])
				start_pend_q <= 1'b1;
			else if (go || mode_q == das_pkg::DAS_MODE_TRIG)
				start_pend_q <= 1'b0;
			if (wr_acc && avs_address == `DAS_OFF_CTRL && avs_writedata[`DAS_CTRL_STOP])
				stop_pend_q <= 1'b1;
			else if (state_q == das_pkg::DAS_S_IDLE)
				stop_pend_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Lane decode for the result write
	// ****************************************************************
	assign got_d     = got_q | {cvt_b.done, cvt_a.done};
	assign all_done  = (got_d & need_q) == need_q;
	assign next_slot = {1'b0, slot_q} + (simul_q ? 4'h2 : 4'h1);

	always_comb
	begin
		lane_vld[0] = (state_q == das_pkg::DAS_S_WAIT) && all_done;
		lane_idx[0] = slot_q;
		lane_res[0] = (!simul_q && need_q[1]) ? cvt_b.res : cvt_a.res;
		lane_vld[1] = lane_vld[0] && simul_q && (slot_q < last_q);
		lane_idx[1] = slot_q + 3'h1;
		lane_res[1] = cvt_b.res;
	end

	// ****************************************************************
	// Scan state machine
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			state_q <= das_pkg::DAS_S_IDLE;
			slot_q  <= 3'h0;
			need_q  <= 2'b00;
			got_q   <= 2'b00;
			req_q   <= 2'b00;
			ch_a_q  <= 3'h0;
			ch_b_q  <= 3'h0;
		end
		else
		begin
			req_q <= 2'b00;
			unique case (state_q)
				das_pkg::DAS_S_IDLE:
				begin
					if (go)
					begin
						slot_q  <= 3'h0;
						state_q <= das_pkg::DAS_S_ISSUE;
					end
				end
				das_pkg::DAS_S_ISSUE:
				begin
					got_q <= 2'b00;
					if (simul_q)
					begin
						// Both stages capture in the same cycle; distinct channels are software's job
						ch_a_q <= list_ch(chlist_q, slot_q);
						ch_b_q <= list_ch(chlist_q, slot_q + 3'h1);
						req_q  <= 2'b11;
						need_q <= 2'b11;
					end
					else if (list_ch(chlist_q, slot_q) >= 3'h4)
					begin
						ch_b_q <= list_ch(chlist_q, slot_q);
						req_q  <= 2'b10;
						need_q <= 2'b10;
					end
					else
					begin
						ch_a_q <= list_ch(chlist_q, slot_q);
						req_q  <= 2'b01;
						need_q <= 2'b01;
					end
					state_q <= das_pkg::DAS_S_WAIT;
				end
				das_pkg::DAS_S_WAIT:
				begin
					got_q <= got_d;
					if (all_done)
					begin
						slot_q  <= next_slot[2:0];
						state_q <= (next_slot > {1'b0, last_q}) ? das_pkg::DAS_S_END
							: das_pkg::DAS_S_ISSUE;
					end
				end
				das_pkg::DAS_S_END:
				begin
					slot_q <= 3'h0;
					if (mode_q == das_pkg::DAS_MODE_LOOP && !stop_pend_q)
						state_q <= das_pkg::DAS_S_ISSUE;
					else
						state_q <= das_pkg::DAS_S_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// Results, limit and zero-crossing checks
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			oor_q  <= 1'b0;
			zc_q   <= 1'b0;
			pos_q  <= '0;
			seen_q <= '0;
			for (int i = 0; i < NCH; i++)
				result_q[i] <= '0;
		end
		else
		begin
			if (go || state_q == das_pkg::DAS_S_END)
			begin
				oor_q <= 1'b0;
				zc_q  <= 1'b0;
			end
			for (int l = 0; l < 2; l++)
			begin
				if (lane_vld[l])
				begin
					result_q[lane_idx[l]] <= lane_res[l];
					pos_q[lane_idx[l]]    <= lane_res[l] >= `DAS_ZC_MID;
					seen_q[lane_idx[l]]   <= 1'b1;
					if (out_of_range(lane_res[l], lim_lo_q[lane_idx[l]], lim_hi_q[lane_idx[l]]))
						oor_q <= 1'b1;
					if (zc_hit(zcsel_q[{lane_idx[l], 1'b0} +: 2], seen_q[lane_idx[l]],
						pos_q[lane_idx[l]], lane_res[l] >= `DAS_ZC_MID))
						zc_q <= 1'b1;
				end
			end
		end
	end

	// ****************************************************************
	// Status and interrupt
	// ****************************************************************
	always_ff @(posedge clk_sys or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			status_q <= 3'h0;
			irq_q    <= 1'b0;
		end
		else
		begin
			// A scan end in the same cycle as the clearing read survives
			for (int b = 0; b < 3; b++)
				if (state_q == das_pkg::DAS_S_END &&
					(b == `DAS_STAT_END || (b == `DAS_STAT_OOR && oor_q) || (b == `DAS_STAT_ZC && zc_q)))
					status_q[b] <= 1'b1;
				// Only bits already returned by the read are cleared, so a set after capture is kept
				else if (rd_status && rdata_q[b])
					status_q[b] <= 1'b0;
			irq_q <= |(status_q & mask_q);
		end
	end

endmodule : das_top

// ==== sim/das_adc_model.sv ====
// Purpose: Sample-and-hold plus converter seen by one sequencer port
// Assumes: Input levels per channel come from the bench
// Notes:   LAT sets answer delay; data toggles when not valid
`timescale 1ns/1ps
module das_adc_model #(parameter int LAT = 2)
(
	input  wire logic        clk_sys,
	input  wire logic        start,
	input  wire logic [2:0]  ch,
	input  wire logic [11:0] vals [8],
	output logic             done,
	output logic [11:0]      data
);
	logic [11:0] held_q;
	int          cnt_q;

	initial
	begin
		done  = 1'b0;
		data  = 12'h000;
		cnt_q = 0;
	end

	// Stale data must never pass for a fresh result
	always @(posedge clk_sys)
	begin
		done <= 1'b0;
		data <= ~data;
		if (start)
		begin
			held_q <= vals[ch];
			cnt_q  <= LAT;
		end
		else if (cnt_q == 1)
		begin
			done  <= 1'b1;
			data  <= held_q;
			cnt_q <= 0;
		end
		else if (cnt_q > 1)
			cnt_q <= cnt_q - 1;
	end
endmodule : das_adc_model

// ==== sim/das_top_properties.sv ====
// Purpose: Port-level checks of the scan sequencer
// Assumes: One clock domain; bound to das_top
// Notes:   Helper flags track converter activity
`timescale 1ns/1ps
module das_top_properties
(
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic [6:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        irq,
	input wire logic        adc_a_start,
	input wire logic [2:0]  adc_a_ch,
	input wire logic        adc_a_done,
	input wire logic        adc_b_start,
	input wire logic [2:0]  adc_b_ch,
	input wire logic        adc_b_done
);
	logic       a_busy_q;
	logic       b_busy_q;
	logic [3:0] acc_age_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// ****************
	// Helper state
	// ****************
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			a_busy_q  <= 1'b0;
			b_busy_q  <= 1'b0;
			acc_age_q <= 4'hf;
		end
		else
		begin
			a_busy_q  <= adc_a_start || (a_busy_q && !adc_a_done);
			b_busy_q  <= adc_b_start || (b_busy_q && !adc_b_done);
			acc_age_q <= !avs_waitrequest ? 4'h0 : acc_age_q + {3'h0, acc_age_q != 4'hf};
		end
	end

	// ****************
	// Assertions
	// ****************
	wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest not low one cycle after request");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	wait_cause_a: assert property (!avs_waitrequest |-> avs_read || avs_write)
		else $error("waitrequest low without request");
	unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address[6:2] == 5'h05 |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	start_pulse_a: assert property (adc_a_start || adc_b_start |=> !adc_a_start && !adc_b_start)
		else $error("start longer than one cycle");
	ch_hold_a: assert property (($stable(adc_a_ch) || adc_a_start) && ($stable(adc_b_ch) || adc_b_start))
		else $error("channel select moved between starts");
	one_flight_a: assert property (!(adc_a_start && a_busy_q) && !(adc_b_start && b_busy_q))
		else $error("start while conversion pending");
	route_b_a: assert property (adc_b_start && !adc_a_start |-> adc_b_ch[2])
		else $error("lone second converter start on low channel");
	irq_fall_a: assert property ($fell(irq) |-> acc_age_q <= 4'h3)
		else $error("irq dropped without register access");
endmodule : das_top_properties

bind das_top das_top_properties u_props (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .irq(irq), .adc_a_start(adc_a_start), .adc_a_ch(adc_a_ch),
	.adc_a_done(adc_a_done), .adc_b_start(adc_b_start), .adc_b_ch(adc_b_ch), .adc_b_done(adc_b_done));

// ==== sim/test_das_top.sv ====
// Purpose: Self-checking bench for the scan sequencer
// Assumes: Two converter models, fast and slow
// Notes:   Irq with all sources unmasked marks scan end
`timescale 1ns/1ps
`include "das_defines.svh"
module test_das_top;
	logic        clk_sys;
	logic        rst_n;
	logic [6:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        trig;
	logic        irq;
	logic        a_start, a_done, b_start, b_done;
	logic [2:0]  a_ch, b_ch;
	logic [11:0] a_data, b_data;
	logic [11:0] vals [8];
	logic [31:0] rd;
	int          n_fail, tests_run, n_sa, n_sb, n_both;

	das_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .trig(trig), .irq(irq), .adc_a_start(a_start), .adc_a_ch(a_ch),
		.adc_a_done(a_done), .adc_a_data(a_data), .adc_b_start(b_start), .adc_b_ch(b_ch),
		.adc_b_done(b_done), .adc_b_data(b_data));
	das_adc_model #(.LAT(2)) u_cva (.clk_sys(clk_sys), .start(a_start), .ch(a_ch), .vals(vals),
		.done(a_done), .data(a_data));
	das_adc_model #(.LAT(7)) u_cvb (.clk_sys(clk_sys), .start(b_start), .ch(b_ch), .vals(vals),
		.done(b_done), .data(b_data));

	initial
	begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys)
	begin
		if (a_start) n_sa <= n_sa + 1;
		if (b_start) n_sb <= n_sb + 1;
		if (a_start && b_start) n_both <= n_both + 1;
	end

	// ****************
	// Bus and check tasks
	// ****************
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("FAIL %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic bus_wr(input logic [6:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= 1'b1;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask : bus_wr

	task automatic bus_rd(input logic [6:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_read    <= 1'b1;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask : bus_rd

	task automatic wait_end(output logic [31:0] st);
		while (irq !== 1'b1) @(posedge clk_sys);
		bus_rd(`DAS_OFF_STATUS, st);
		repeat (2) @(posedge clk_sys);
		check("irq clear", {31'h0, irq}, 32'h0);
	endtask : wait_end

	task automatic run_scan(input logic [31:0] ctrl, output logic [31:0] st);
		bus_wr(`DAS_OFF_CTRL, ctrl);
		wait_end(st);
	endtask : run_scan

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset;
		bus_rd(`DAS_OFF_CTRL, rd);
		check("ctrl", rd, 32'h00000700);
		bus_rd(`DAS_OFF_CHLIST, rd);
		check("chlist", rd, 32'h76543210);
		bus_rd(7'h40, rd);
		check("limit", rd, 32'h0fff0000);
		bus_rd(7'h14, rd);
		check("unmapped", rd, 32'h0);
	endtask : t_reset

	task automatic t_seq(input logic [31:0] lim1, input logic [31:0] exp_st);
		logic [2:0] chs [4] = '{3'h5, 3'h0, 3'h7, 3'h2};
		int a0 = n_sa;
		int b0 = n_sb;
		bus_wr(7'h44, lim1);
		bus_wr(`DAS_OFF_CHLIST, 32'h00002705);
		run_scan(32'h00000308, rd);
		check("seq status", rd, exp_st);
		for (int i = 0; i < 4; i++)
		begin
			bus_rd(7'h20 + 7'(4 * i), rd);
			check("seq result", rd, {20'h0, vals[chs[i]]});
		end
		check("a starts", n_sa - a0, 32'h2);
		check("b starts", n_sb - b0, 32'h2);
	endtask : t_seq

	task automatic t_sim;
		int c0 = n_both;
		bus_wr(`DAS_OFF_CHLIST, 32'h00000063);
		run_scan(32'h0000010c, rd);
		check("sim status", rd, 32'h1);
		check("sim both", n_both - c0, 32'h1);
		bus_rd(7'h20, rd);
		check("sim res0", rd, {20'h0, vals[3]});
		bus_rd(7'h24, rd);
		check("sim res1", rd, {20'h0, vals[6]});
	endtask : t_sim

	task automatic t_trig;
		int b0 = n_sb;
		bus_wr(`DAS_OFF_CHLIST, 32'h00000004);
		bus_wr(`DAS_OFF_CTRL, 32'h00000009);
		repeat (20) @(posedge clk_sys);
		check("trig start bit", n_sb - b0, 32'h0);
		for (int k = 1; k < 3; k++)
		begin
			@(posedge clk_sys) trig <= 1'b1;
			@(posedge clk_sys) trig <= 1'b0;
			repeat (6) @(posedge clk_sys);
			trig <= 1'b1;
			@(posedge clk_sys) trig <= 1'b0;
			wait_end(rd);
			repeat (30) @(posedge clk_sys);
			check("trig scans", n_sb - b0, 32'(k));
		end
	endtask : t_trig

	task automatic t_loop;
		int a0 = n_sa;
		bus_wr(`DAS_OFF_CHLIST, 32'h00000001);
		bus_wr(`DAS_OFF_CTRL, 32'h0000000a);
		while (n_sa - a0 < 3) @(posedge clk_sys);
		bus_wr(`DAS_OFF_CTRL, 32'h00000012);
		repeat (30) @(posedge clk_sys);
		bus_rd(`DAS_OFF_STATUS, rd);
		check("loop busy", rd & 32'h00000100, 32'h0);
		a0 = n_sa;
		repeat (30) @(posedge clk_sys);
		check("loop halted", n_sa - a0, 32'h0);
	endtask : t_loop

	task automatic t_zc;
		logic [1:0]  zsel [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
		logic [11:0] zval [5] = '{12'h100, 12'h010, 12'h900, 12'h100, 12'h900};
		logic [31:0] zexp [5] = '{32'h1, 32'h1, 32'h5, 32'h5, 32'h5};
		bus_wr(`DAS_OFF_CHLIST, 32'h00000000);
		for (int i = 0; i < 5; i++)
		begin
			bus_wr(`DAS_OFF_ZCCTRL, {30'h0, zsel[i]});
			vals[0] <= zval[i];
			run_scan(32'h00000008, rd);
			check("zc status", rd, zexp[i]);
		end
	endtask : t_zc

	task automatic t_mask;
		bus_wr(`DAS_OFF_ZCCTRL, 32'h0);
		bus_wr(`DAS_OFF_MASK, 32'h00000006);
		bus_wr(`DAS_OFF_CTRL, 32'h00000008);
		repeat (40) @(posedge clk_sys);
		check("masked irq", {31'h0, irq}, 32'h0);
		bus_rd(`DAS_OFF_STATUS, rd);
		check("masked status", rd, 32'h1);
	endtask : t_mask

	task automatic stop_test;
		if (n_fail == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test

	initial
	begin
		{avs_read, avs_write, trig, rst_n} = 4'h0;
		avs_address   = 7'h00;
		avs_writedata = 32'h0;
		{n_fail, tests_run, n_sa, n_sb, n_both} = '0;
		for (int c = 0; c < 8; c++) vals[c] = 12'(c * 256 + 16);
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_reset;
		bus_wr(`DAS_OFF_MASK, 32'h00000007);
		t_seq(32'h0fff0100, 32'h3);
		t_seq(32'h00050000, 32'h3);
		t_seq(32'h0fff0000, 32'h1);
		t_sim;
		t_trig;
		t_loop;
		t_zc;
		t_mask;
		stop_test;
	end

	// Whole run needs under a thousand cycles
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		n_fail++;
		stop_test;
	end
endmodule : test_das_top
